// ### hvs_sequencer.sv
// Module: cycle, suppression and zero-voltage sequencer with Avalon slave
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Behaviour
// - Max flux strobe gated to ion transfer
// - Step-7 electron transfer; fast rate suppresses both
// - Fast selects live counter, slow held register
// - Cycle counter: seven ion, one electron
// - F and I clear G, H bits
// - H and I give fourth-ion flag, polarity
// - Polarity marks electron cycle, plus complement
// - Ion code: fourth flag or polarity by mode
// - Both mode bits high hold ion code low
// - Mode latch cleared at electron start advances counter
// - Mode counter skips 0,1 straight to 1,1
// - Ion reset drives electron code low
// - Sixth electron step sets electron code high
// - Status bit high when nothing unsuppressed
// - Status change fires programmable-width mode pulse
// - Codes and polarity form two voltage selects
// - Idle: latches 3, 4, 5 set, zero and stab high
// - Change case: cycle end, mode pulse clear latches
// - Change case: stabilise after third, end fourth
// - End of stabilisation sets latches 3, 4
// - Slow rate: blocked until buffer drained
// - No change: latch 4 stays, short path
// - No change: first starts, second ends stabilisation
// - Step advance blocked by zero or inhibit
module hvs_sequencer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Sibling logic pulses and levels
	input wire hvs_pkg::hvs_pulse_t pulse_in,
	input wire logic [4:0] step_count_in,
	input wire logic [4:0] step_reg_in,
	input wire logic advance_inhibit_in,
	// Transfer and ramp
	output logic ion_transfer_strobe_out,
	output logic electron_transfer_strobe_out,
	output logic transfer_pulse_out,
	output logic transfer_pulse_b_out,
	output logic [4:0] ramp_step_out,
	output logic ramp_source_gate_out,
	output logic ramp_source_gate_b_out,
	// Cycle, polarity and suppression
	output logic [3:0] cycle_state_out,
	output logic polarity_electron_out,
	output logic polarity_electron_b_out,
	output logic fourth_ion_cycle_flag_out,
	output logic mode_cmd_bit_one_out,
	output logic mode_cmd_bit_two_out,
	output logic ion_suppress_code_out,
	output logic electron_suppress_code_out,
	output logic suppressed_status_bit_out,
	output logic status_toggle_pulse_out,
	output logic suppressed_mode_start_pulse_out,
	output logic suppressed_mode_start_pulse_b_out,
	output logic [1:0] supp_select_out,
	// Zero voltage and stabilisation
	output logic voltage_zero_force_out,
	output logic stabilize_b_out,
	output logic step_advance_pulse_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [hvs_pkg::HVS_NPULSE-1:0] pulse_vec;
	logic [hvs_pkg::HVS_NPULSE-1:0] pulse_prev;
	logic [hvs_pkg::HVS_NPULSE-1:0] stb_vec;
	hvs_pkg::hvs_pulse_t stb;
	logic fast_rate_mode;
	logic [7:0] ism_width;
	logic bus_ack;
	logic bus_req;
	logic [31:0] status_word;
	logic f_q, g_q, h_q, i_q;
	logic polarity_electron;
	logic fourth_ion;
	logic mode_latch;
	logic mc1, mc2;
	logic next_mc1, next_mc2;
	logic ion_suppress_code;
	logic electron_suppress_code;
	logic suppressed_status_bit;
	logic sid_prev;
	logic sid_toggle;
	logic [7:0] ism_cnt;
	logic ism_start;
	logic latch3, latch4, latch5;
	logic [2:0] sun_cnt;
	logic [2:0] stab_start;
	logic sun_admit;
	logic stab_end;

	// ----------------------------------------------------------------
	// Input strobes
	// ----------------------------------------------------------------
	assign pulse_vec = pulse_in;
	assign stb = stb_vec;

	// Previous level of every pulse input
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pulse_prev <= '0;
		end else begin
			pulse_prev <= pulse_vec;
		end
	end

	// Rising edge of each input becomes a one-cycle strobe
	for (genvar k = 0; k < hvs_pkg::HVS_NPULSE; k++) begin : g_edge
		assign stb_vec[k] = pulse_vec[k] & ~pulse_prev[k];
	end

	// ----------------------------------------------------------------
	// Avalon-MM slave, one wait state on every access
	// ----------------------------------------------------------------
	assign bus_req = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = bus_req & ~bus_ack;

	// Ack flag alternates so each access completes on its second edge
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req & ~bus_ack;
		end
	end

	// Control register writes
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			fast_rate_mode <= hvs_pkg::HVS_RST_FAST;
			ism_width <= hvs_pkg::HVS_RST_WIDTH;
		end else if (avs_write_in && bus_ack
				&& avs_address_in == hvs_pkg::HVS_ADDR_CTRL) begin
			fast_rate_mode <= avs_writedata_in[hvs_pkg::HVS_CTRL_FAST_BIT];
			ism_width <= avs_writedata_in[hvs_pkg::HVS_CTRL_WIDTH_LSB +:
				hvs_pkg::HVS_CTRL_WIDTH_W];
		end
	end

	// Status word gathers the sequencer state
	always_comb begin
		status_word = '0;
		status_word[hvs_pkg::HVS_ST_CYCLE_LSB +: 4] = {f_q, g_q, h_q, i_q};
		status_word[hvs_pkg::HVS_ST_MODE_LSB +: 2] = {mc2, mc1};
		status_word[hvs_pkg::HVS_ST_ISC_BIT] = ion_suppress_code;
		status_word[hvs_pkg::HVS_ST_ESC_BIT] = electron_suppress_code;
		status_word[hvs_pkg::HVS_ST_SID_BIT] = suppressed_status_bit;
		status_word[hvs_pkg::HVS_ST_POL_BIT] = polarity_electron;
		status_word[hvs_pkg::HVS_ST_ZERO_BIT] = latch3;
		status_word[hvs_pkg::HVS_ST_STAB_B_BIT] = stabilize_b_out;
		status_word[hvs_pkg::HVS_ST_L4_BIT] = latch4;
		status_word[hvs_pkg::HVS_ST_L5_BIT] = latch5;
	end

	// Read data loaded in the wait cycle, stands at the completing edge
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			avs_readdata_out <= 32'h00000000;
		end else if (avs_read_in && !bus_ack) begin
			unique case (avs_address_in)
				hvs_pkg::HVS_ADDR_CTRL: begin
					avs_readdata_out <= {16'h0000, ism_width, 7'h00,
						fast_rate_mode};
				end
				hvs_pkg::HVS_ADDR_STATUS: begin
					avs_readdata_out <= status_word;
				end
				default: begin
					avs_readdata_out <= 32'h00000000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Transfer logic and ramp gate
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ion_transfer_strobe_out <= 1'b0;
			electron_transfer_strobe_out <= 1'b0;
			transfer_pulse_out <= 1'b0;
			transfer_pulse_b_out <= 1'b1;
		end else begin
			ion_transfer_strobe_out <= stb.max_flux & ~polarity_electron
				& ~fast_rate_mode;
			electron_transfer_strobe_out <= stb.det7 & polarity_electron
				& ~fast_rate_mode;
			transfer_pulse_out <= ~fast_rate_mode & ((stb.max_flux
				& ~polarity_electron) | (stb.det7 & polarity_electron));
			transfer_pulse_b_out <= ~(~fast_rate_mode & ((stb.max_flux
				& ~polarity_electron) | (stb.det7 & polarity_electron)));
		end
	end

	// Live counter at fast rate, held register at slow rate
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ramp_step_out <= 5'h00;
			ramp_source_gate_out <= 1'b0;
			ramp_source_gate_b_out <= 1'b1;
		end else begin
			ramp_step_out <= fast_rate_mode ? step_count_in
				: step_reg_in;
			ramp_source_gate_out <= fast_rate_mode;
			ramp_source_gate_b_out <= ~fast_rate_mode;
		end
	end

	// ----------------------------------------------------------------
	// Cycle counter and polarity
	// ----------------------------------------------------------------
	// Johnson sequence of eight states, forbidden states flushed
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			{f_q, g_q, h_q, i_q} <= hvs_pkg::HVS_CYCLE_RESET;
		end else if (stb.cycle_adv) begin
			f_q <= ~i_q;
			g_q <= f_q & (f_q | i_q);
			h_q <= g_q & (f_q | i_q);
			i_q <= h_q;
		end
	end

	assign fourth_ion = h_q & ~i_q;
	assign polarity_electron = ~h_q & i_q;

	// ----------------------------------------------------------------
	// Mode command counter and ion suppression code
	// ----------------------------------------------------------------
	// Two-bit ripple count, state 0,1 replaced by 1,1 at once
	always_comb begin
		next_mc1 = ~mc1;
		next_mc2 = mc2 ^ mc1;
		if (!next_mc1 && next_mc2) begin
			next_mc1 = 1'b1;
		end
	end

	// Command latch; its clear at electron start advances the count
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mode_latch <= 1'b0;
			{mc2, mc1} <= hvs_pkg::HVS_MODE_RESET;
		end else begin
			if (stb.mode_chg) begin
				mode_latch <= 1'b1;
			end else if (stb.elec_start) begin
				mode_latch <= 1'b0;
			end
			if (mode_latch && stb.elec_start) begin
				mc1 <= next_mc1;
				mc2 <= next_mc2;
			end
		end
	end

	// Ion code chosen by the mode bits
	always_comb begin
		if (mc1 && mc2) begin
			ion_suppress_code = 1'b0;
		end else if (mc1) begin
			ion_suppress_code = polarity_electron;
		end else if (!mc2) begin
			ion_suppress_code = fourth_ion;
		end else begin
			ion_suppress_code = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Electron suppression code
	// ----------------------------------------------------------------
	// Sixth electron step sets, ion reset clears; set wins
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			electron_suppress_code <= 1'b0;
		end else if (polarity_electron
				&& step_count_in[3:1] == hvs_pkg::HVS_STEP6_BCD) begin
			electron_suppress_code <= 1'b1;
		end else if (stb.ion_reset) begin
			electron_suppress_code <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Suppressed status and mode pulse
	// ----------------------------------------------------------------
	assign suppressed_status_bit = ~(ion_suppress_code | (polarity_electron & ~electron_suppress_code));
	assign sid_toggle = suppressed_status_bit ^ sid_prev;
	assign ism_start = sid_toggle & (ism_cnt == 8'h00);

	// Status bit history and toggle pulse
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sid_prev <= 1'b1;
			status_toggle_pulse_out <= 1'b0;
		end else begin
			sid_prev <= suppressed_status_bit;
			status_toggle_pulse_out <= sid_toggle;
		end
	end

	// One-shot of programmable width, retriggered by later toggles
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ism_cnt <= 8'h00;
		end else if (sid_toggle) begin
			ism_cnt <= (ism_width == 8'h00) ? 8'h01 : ism_width;
		end else if (ism_cnt != 8'h00) begin
			ism_cnt <= ism_cnt - 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Zero voltage and stabilisation latches
	// ----------------------------------------------------------------
	assign stab_start = latch4 ? hvs_pkg::HVS_STAB_START_SAME
		: hvs_pkg::HVS_STAB_START_CHG;
	// Sun pulse passes only with zero off; buffer hold blocks it only while stabilising
	assign sun_admit = stb.sun & ~latch3
		& (latch5 | stabilize_b_out);
	assign stab_end = sun_admit
		&& (sun_cnt == stab_start);

	// Latch 3 cleared at cycle end, latch 4 at mode pulse start; both set at stabilisation end
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			latch3 <= 1'b1;
			latch4 <= 1'b1;
		end else begin
			if (stab_end) begin
				latch3 <= 1'b1;
			end else if (stb.cycle_end) begin
				latch3 <= 1'b0;
			end
			if (stab_end) begin
				latch4 <= 1'b1;
			end else if (ism_start) begin
				latch4 <= 1'b0;
			end
		end
	end

	// Latch 5 holds the slow-rate sequence until the buffer drains
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			latch5 <= 1'b1;
		end else if (stb.drained) begin
			latch5 <= 1'b1;
		end else if (stb.slow_xfer && !fast_rate_mode) begin
			latch5 <= 1'b0;
		end
	end

	// Admitted sun pulses counted in place of latches 1 and 2
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sun_cnt <= 3'h0;
			stabilize_b_out <= 1'b1;
		end else if (stb.cycle_end) begin
			sun_cnt <= 3'h0;
			stabilize_b_out <= 1'b1;
		end else if (stab_end) begin
			sun_cnt <= 3'h0;
			stabilize_b_out <= 1'b1;
		end else if (sun_admit) begin
			sun_cnt <= sun_cnt + 3'h1;
			if (sun_cnt + 3'h1 == stab_start) begin
				stabilize_b_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			step_advance_pulse_out <= 1'b0;
			supp_select_out <= 2'b00;
			suppressed_mode_start_pulse_out <= 1'b0;
			suppressed_mode_start_pulse_b_out <= 1'b1;
		end else begin
			step_advance_pulse_out <= stb.step_adv & ~latch3
				& ~advance_inhibit_in;
			// Bit 0 is the 6+0 line, bit 1 the 6+25 line
			supp_select_out <= polarity_electron ? {electron_suppress_code, ~electron_suppress_code}
				: {ion_suppress_code, ion_suppress_code};
			suppressed_mode_start_pulse_out <= sid_toggle
				| (ism_cnt > 8'h01);
			suppressed_mode_start_pulse_b_out <= ~(sid_toggle
				| (ism_cnt > 8'h01));
		end
	end

	// Level outputs taken straight from state flops and decode
	assign cycle_state_out = {f_q, g_q, h_q, i_q};
	assign polarity_electron_out = polarity_electron;
	assign polarity_electron_b_out = ~polarity_electron;
	assign fourth_ion_cycle_flag_out = fourth_ion;
	assign mode_cmd_bit_one_out = mc1;
	assign mode_cmd_bit_two_out = mc2;
	assign ion_suppress_code_out = ion_suppress_code;
	assign electron_suppress_code_out = electron_suppress_code;
	assign suppressed_status_bit_out = suppressed_status_bit;
	assign voltage_zero_force_out = latch3;

endmodule : hvs_sequencer

// ### hvs_pkg.sv
// Package: constants and carrier types for the voltage cycle sequencer
package hvs_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] HVS_ADDR_CTRL = 4'h0;
	localparam logic [3:0] HVS_ADDR_STATUS = 4'h4;

	// ----------------------------------------------------------------
	// Control register fields and reset values
	// ----------------------------------------------------------------
	localparam int HVS_CTRL_FAST_BIT = 0;
	localparam int HVS_CTRL_WIDTH_LSB = 8;
	localparam int HVS_CTRL_WIDTH_W = 8;
	localparam logic HVS_RST_FAST = 1'b0;
	localparam logic [7:0] HVS_RST_WIDTH = 8'h0A;

	// ----------------------------------------------------------------
	// Status register field positions
	// ----------------------------------------------------------------
	localparam int HVS_ST_CYCLE_LSB = 0;
	localparam int HVS_ST_MODE_LSB = 4;
	localparam int HVS_ST_ISC_BIT = 6;
	localparam int HVS_ST_ESC_BIT = 7;
	localparam int HVS_ST_SID_BIT = 8;
	localparam int HVS_ST_POL_BIT = 9;
	localparam int HVS_ST_ZERO_BIT = 10;
	localparam int HVS_ST_STAB_B_BIT = 11;
	localparam int HVS_ST_L4_BIT = 12;
	localparam int HVS_ST_L5_BIT = 13;

	// ----------------------------------------------------------------
	// Sequencing constants
	// ----------------------------------------------------------------
	localparam logic [3:0] HVS_CYCLE_RESET = 4'h0;
	localparam logic [1:0] HVS_MODE_RESET = 2'h0;
	localparam logic [2:0] HVS_STAB_START_CHG = 3'h3;
	localparam logic [2:0] HVS_STAB_START_SAME = 3'h1;
	localparam logic [2:0] HVS_STEP6_BCD = 3'h3;
	localparam int HVS_NPULSE = 11;

	// ----------------------------------------------------------------
	// Pulse inputs from the sibling logic, all on clk_in
	// ----------------------------------------------------------------
	typedef struct packed {
		logic max_flux;
		logic det7;
		logic cycle_adv;
		logic ion_reset;
		logic elec_start;
		logic mode_chg;
		logic cycle_end;
		logic sun;
		logic slow_xfer;
		logic drained;
		logic step_adv;
	} hvs_pulse_t;

endpackage : hvs_pkg

// ### hvs_assertions.sv
// Checker: port-level properties of the voltage cycle sequencer
`timescale 1ns/1ps
module hvs_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Watched ports
	input wire logic advance_inhibit_in,
	input wire logic [3:0] cycle_state_out,
	input wire logic polarity_electron_out,
	input wire logic polarity_electron_b_out,
	input wire logic fourth_ion_cycle_flag_out,
	input wire logic mode_cmd_bit_one_out,
	input wire logic mode_cmd_bit_two_out,
	input wire logic ion_suppress_code_out,
	input wire logic electron_suppress_code_out,
	input wire logic suppressed_status_bit_out,
	input wire logic status_toggle_pulse_out,
	input wire logic [1:0] supp_select_out,
	input wire logic voltage_zero_force_out,
	input wire logic step_advance_pulse_out,
	// Complement pairs
	input wire logic transfer_pulse_out,
	input wire logic transfer_pulse_b_out,
	input wire logic ramp_source_gate_out,
	input wire logic ramp_source_gate_b_out,
	input wire logic suppressed_mode_start_pulse_out,
	input wire logic suppressed_mode_start_pulse_b_out
);
	// Short aliases for the suppression terms
	wire logic pol = polarity_electron_out;
	wire logic ion_suppress_code = ion_suppress_code_out;
	wire logic electron_suppress_code = electron_suppress_code_out;
	wire logic suppressed_status_bit = suppressed_status_bit_out;
	wire logic [3:0] cs = cycle_state_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_pol_decode: assert property (
		pol == (!cs[1] && cs[0]) && polarity_electron_b_out != pol)
		else $error("polarity decode wrong");
	chk_fourth_flag: assert property (
		fourth_ion_cycle_flag_out == (cs[1] && !cs[0]))
		else $error("fourth ion flag wrong");
	chk_cycle_step: assert property (
		cs != $past(cs) |-> cs == {!$past(cs[0]), $past(cs[3:1])})
		else $error("cycle counter left its sequence");
	chk_isc_mode: assert property (
		ion_suppress_code == (!mode_cmd_bit_two_out && (mode_cmd_bit_one_out ? pol
			: fourth_ion_cycle_flag_out)))
		else $error("ion code ignores mode");
	chk_mode_skip: assert property (
		!(mode_cmd_bit_two_out && !mode_cmd_bit_one_out))
		else $error("mode counter rests in 0,1");
	chk_sid_value: assert property (
		suppressed_status_bit == !(ion_suppress_code || (pol && !electron_suppress_code)))
		else $error("status bit wrong");
	chk_toggle_pulse: assert property (
		status_toggle_pulse_out == ($past(suppressed_status_bit) != $past(suppressed_status_bit, 2)))
		else $error("toggle pulse does not follow status change");
	chk_select_map: assert property (
		supp_select_out == ($past(pol) ? {$past(electron_suppress_code), !$past(electron_suppress_code)}
			: {$past(ion_suppress_code), $past(ion_suppress_code)}))
		else $error("voltage select wrong");
	chk_step_block: assert property (
		step_advance_pulse_out |-> !$past(voltage_zero_force_out)
			&& !$past(advance_inhibit_in))
		else $error("step advance while blocked");
	chk_comp_pairs: assert property (
		transfer_pulse_b_out != transfer_pulse_out
			&& ramp_source_gate_b_out != ramp_source_gate_out
			&& suppressed_mode_start_pulse_b_out
			!= suppressed_mode_start_pulse_out)
		else $error("complement output does not mirror its pair");
endmodule : hvs_checker

// ### hvs_partner.sv
// Partner: sibling step counter, step register and pulse sources
`timescale 1ns/1ps
module hvs_partner (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Bench requests and sequencer strobes
	input wire logic [10:0] kick_in,
	input wire logic step_adv_in,
	input wire logic xfer_in,
	// Toward the sequencer
	output hvs_pkg::hvs_pulse_t pulse_out,
	output logic [4:0] count_out,
	output logic [4:0] reg_out
);
	// One-cycle pulses, always a low cycle before the next rise
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pulse_out <= '0;
		end else begin
			pulse_out <= hvs_pkg::hvs_pulse_t'(kick_in & ~pulse_out);
		end
	end
	// Step counter: resets load the cycle start counts
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || pulse_out.ion_reset) begin
			count_out <= 5'h02;
		end else if (pulse_out.elec_start) begin
			count_out <= 5'h11;
		end else if (step_adv_in) begin
			count_out <= count_out + 5'h01;
		end
	end
	// Step register takes the counter on each transfer
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			reg_out <= 5'h00;
		end else if (xfer_in) begin
			reg_out <= count_out;
		end
	end
endmodule : hvs_partner

// ### test_hvs_sequencer.sv
// Testbench: self-checking run of the voltage cycle sequencer
`timescale 1ns/1ps
module test_hvs_sequencer;
	localparam int MF = 10, D7 = 9, CA = 8, IR = 7, ES = 6, MC = 5;
	localparam int CE = 4, SUN = 3, SX = 2, DR = 1, SA = 0;
	logic clk_in, rst_b_in, avs_read_in, avs_write_in, advance_inhibit_in;
	logic [3:0] avs_address_in, cycle_state_out, s;
	logic [31:0] avs_writedata_in, avs_readdata_out, q, seed;
	logic avs_waitrequest_out, transfer_pulse_out, transfer_pulse_b_out;
	hvs_pkg::hvs_pulse_t pulse_in;
	logic [4:0] step_count_in, step_reg_in, ramp_step_out;
	logic ion_transfer_strobe_out, electron_transfer_strobe_out;
	logic ramp_source_gate_out, ramp_source_gate_b_out;
	logic polarity_electron_out, polarity_electron_b_out;
	logic fourth_ion_cycle_flag_out, mode_cmd_bit_one_out;
	logic mode_cmd_bit_two_out, ion_suppress_code_out;
	logic electron_suppress_code_out, suppressed_status_bit_out;
	logic status_toggle_pulse_out, suppressed_mode_start_pulse_out;
	logic suppressed_mode_start_pulse_b_out, voltage_zero_force_out;
	logic stabilize_b_out, step_advance_pulse_out;
	logic [1:0] supp_select_out, mc;
	logic [1:0] mexp [4] = '{2'b00, 2'b10, 2'b11, 2'b00};
	logic [10:0] kick;
	int fail_count, checks_done, n_ion, n_el, n_tr, n_ism, a, w;
	// Design and far side
	hvs_sequencer i_dut (.*);
	hvs_partner i_far (.clk_in, .rst_b_in, .kick_in(kick),
		.step_adv_in(step_advance_pulse_out), .xfer_in(transfer_pulse_out),
		.pulse_out(pulse_in), .count_out(step_count_in),
		.reg_out(step_reg_in));
	// Clock and pulse counters
	always #25 clk_in = !clk_in;
	always @(posedge clk_in) begin
		n_ion <= n_ion + ion_transfer_strobe_out;
		n_el <= n_el + electron_transfer_strobe_out;
		n_tr <= n_tr + transfer_pulse_out;
		n_ism <= n_ism + suppressed_mode_start_pulse_out;
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
			fail_count++;
		end
	endtask : chk
	task automatic bus(input logic wr, input logic [3:0] ad,
		input logic [31:0] d);
		@(posedge clk_in);
		avs_write_in <= wr;
		avs_read_in <= !wr;
		avs_address_in <= ad;
		avs_writedata_in <= d;
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
	endtask : bus
	task automatic pulse(input int b);
		@(posedge clk_in);
		kick <= 11'h001 << b;
		@(posedge clk_in);
		kick <= '0;
		repeat (3) @(posedge clk_in);
	endtask : pulse
	task automatic cyc();
		logic pol, ion_suppress_code;
		pulse(CA);
		s = {!s[0], s[3:1]};
		pol = !s[1] && s[0];
		ion_suppress_code = mc == 2'b00 ? s[1] && !s[0] : mc == 2'b10 && pol;
		chk(cycle_state_out, s);
		chk(polarity_electron_b_out, !pol);
		chk(fourth_ion_cycle_flag_out, s[1] && !s[0]);
		chk(ion_suppress_code_out, ion_suppress_code);
		chk(suppressed_status_bit_out, !(ion_suppress_code || pol));
		chk(supp_select_out, pol ? 2'b01 : {ion_suppress_code, ion_suppress_code});
	endtask : cyc
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		finish_test();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{clk_in, rst_b_in, avs_read_in, avs_write_in} = '0;
		{avs_address_in, avs_writedata_in, kick, advance_inhibit_in} = '0;
		{fail_count, checks_done, n_ion, n_el, n_tr, n_ism} = '0;
		seed = 32'hBE51B271;
		s = 4'h0;
		mc = 2'b00;
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		bus(1'b0, hvs_pkg::HVS_ADDR_CTRL, 0);
		chk(q, 32'h00000A00);
		bus(1'b0, hvs_pkg::HVS_ADDR_STATUS, 0);
		chk(q, 32'h00003D00);
		bus(1'b1, 4'hC, 32'hFFFFFFFF);
		bus(1'b0, 4'hC, 0);
		chk(q, 32'h00000000);
		$display("registers done");
		pulse(SUN);
		pulse(SA);
		chk(stabilize_b_out, 1'b1);
		chk(step_count_in, 5'h02);
		pulse(CE);
		chk(voltage_zero_force_out, 1'b0);
		advance_inhibit_in <= 1'b1;
		pulse(SA);
		chk(step_count_in, 5'h02);
		advance_inhibit_in <= 1'b0;
		pulse(SA);
		chk(step_count_in, 5'h03);
		pulse(SUN);
		chk(stabilize_b_out, 1'b0);
		pulse(SUN);
		chk({stabilize_b_out, voltage_zero_force_out}, 2'b11);
		$display("short stabilisation done");
		pulse(CE);
		pulse(SX);
		pulse(SUN);
		pulse(SUN);
		chk({stabilize_b_out, voltage_zero_force_out}, 2'b00);
		pulse(DR);
		pulse(SUN);
		chk({stabilize_b_out, voltage_zero_force_out}, 2'b11);
		$display("slow rate hold done");
		seed = xs(seed);
		w = int'(seed % 15) + 1;
		bus(1'b1, hvs_pkg::HVS_ADDR_CTRL, {16'h0, 8'(w), 8'h00});
		a = n_ism;
		repeat (3) cyc();
		repeat (20) @(posedge clk_in);
		chk(n_ism - a, w);
		bus(1'b0, hvs_pkg::HVS_ADDR_STATUS, 0);
		chk(q[13:12], 2'b10);
		pulse(CE);
		chk(voltage_zero_force_out, 1'b0);
		repeat (2) pulse(SUN);
		chk(stabilize_b_out, 1'b1);
		pulse(SUN);
		chk(stabilize_b_out, 1'b0);
		pulse(SUN);
		chk({stabilize_b_out, voltage_zero_force_out}, 2'b11);
		bus(1'b0, hvs_pkg::HVS_ADDR_STATUS, 0);
		chk(q[12], 1'b1);
		$display("long stabilisation done");
		pulse(MF);
		pulse(D7);
		chk(n_ion, 1);
		chk(n_el, 0);
		chk(n_tr, 1);
		chk(ramp_step_out, step_reg_in);
		for (int m = 0; m < 3; m++) begin
			repeat (8) begin
				cyc();
				if (m == 0 && s == 4'b0001) begin
					chk(electron_suppress_code_out, 1'b0);
					pulse(ES);
					pulse(CE);
					repeat (5) pulse(SA);
					repeat (2) @(posedge clk_in);
					chk(electron_suppress_code_out, 1'b1);
					chk(supp_select_out, 2'b10);
					chk(ramp_step_out, step_reg_in);
					pulse(D7);
					chk(n_el, 1);
					chk(n_tr, 2);
					// Leave steps 6 and 7 so the ion reset can clear
					repeat (2) pulse(SA);
					pulse(IR);
					chk(electron_suppress_code_out, 1'b0);
				end
			end
			pulse(MC);
			pulse(ES);
			mc = mexp[m + 1];
			chk({mode_cmd_bit_one_out, mode_cmd_bit_two_out}, mc);
		end
		$display("cycle and mode walk done");
		bus(1'b1, hvs_pkg::HVS_ADDR_CTRL, {16'h0, 8'(w), 8'h01});
		pulse(MF);
		pulse(SA);
		chk(n_tr, 2);
		chk(ramp_source_gate_out, 1'b1);
		@(posedge clk_in);
		chk(ramp_step_out, step_count_in);
		$display("fast rate done");
		finish_test();
	end
endmodule : test_hvs_sequencer
bind hvs_sequencer hvs_checker i_chk (.clk_in, .rst_b_in,
	.advance_inhibit_in, .cycle_state_out, .polarity_electron_out,
	.polarity_electron_b_out, .fourth_ion_cycle_flag_out,
	.mode_cmd_bit_one_out, .mode_cmd_bit_two_out, .ion_suppress_code_out,
	.electron_suppress_code_out, .suppressed_status_bit_out,
	.status_toggle_pulse_out, .supp_select_out, .voltage_zero_force_out,
	.step_advance_pulse_out, .transfer_pulse_out, .transfer_pulse_b_out,
	.ramp_source_gate_out, .ramp_source_gate_b_out,
	.suppressed_mode_start_pulse_out, .suppressed_mode_start_pulse_b_out);
